// >>> psc_power_manager.sv
// power manager end: sleep depth, wake, clock gating and performance level
// Behaviour
// - power-on: active, lowest level, domains active
// - always enabled, documented resets never reinitialise
// - sleep on wait-for-interrupt or sleep-after-handler return, depth chosen
// - software reads back depth before sleeping
// - sleep-ready flag after regulator stable
// - idle: cpu stops, bus clock on request
// - standby wake: async, or run-in-standby sync
// - standby: only requested clocks keep running
// - standby wake: handler or resume per mask
// - standby regulator low-power unless task needs
// - sleep-after-handler enters idle or standby
// - backup entry resets all but retention bit; the code also keeps bus_off_r over backup entry
// - backup exits only on backup reset
// - off exits on reset pin or power
// - retention clear: release pins on exit
// - retention set: hold until written zero
// - level change without stall, only active
// - software lowers bus clock before lowering
// - level-ready flag on completed transition
// - freeze write off lowest: discard, violation
// - frozen: higher level request discarded, violation
// - bus clock disabled: back only by reset
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module psc_power_manager (
    // link to the cpu side
    psc_link_if.dev  lnk,
    // wake and reset sources
    input  wire logic irq_i,
    input  wire logic async_irq_i,
    input  wire logic sync_irq_i,
    input  wire logic sync_irq_keep_running_in_standby_i,
    input  wire logic backup_reset_i,
    input  wire logic ext_reset_n_i,
    input  wire logic power_reset_i,
    // clock, regulator and bus status
    input  wire logic bus_req_i,
    input  wire logic clk_keep_i,
    input  wire logic bg_task_power_i,
    input  wire logic vreg_stable_i,
    input  wire logic bus_clk_disable_i,
    // power outputs
    output logic [2:0] mode_o,
    output logic       main_clk_en_o,
    output logic       bus_clk_en_o,
    output logic       generic_clock_en_o,
    output logic       regulator_lp_o,
    output logic       io_hold_o,
    output logic       perf_level_o,
    output logic       access_violation_o
);
    psc_pkg::psc_mode_t         mode_r;
    psc_pkg::psc_mode_t         mode_nxt;
    logic [2:0]                 depth_r;
    logic                       io_retention_hold_r;
    logic                       io_hold_r;
    logic                       perf_level_select_r;
    logic                       level_r;
    logic                       freeze_r;
    logic                       perf_level_ready_flag_r;
    logic                       slprdy_r;
    logic                       bus_off_r;
    logic [psc_pkg::PL_CNT_W-1:0] pl_cnt_r;
    logic                       wr;
    logic                       freeze_ok;
    logic                       freeze_new;
    logic                       sel_reject;
    logic                       enter_backup;
    logic                       leave_backup;
    logic                       pl_done;
    logic                       after_handler;

    // ****************************************
    // depth decode
    // ****************************************
    function automatic psc_pkg::psc_mode_t depth_mode(input logic [2:0] d);
        case (d)
            psc_pkg::DEPTH_IDLE:    depth_mode = psc_pkg::MODE_IDLE;
            psc_pkg::DEPTH_STANDBY: depth_mode = psc_pkg::MODE_STANDBY;
            psc_pkg::DEPTH_BACKUP:  depth_mode = psc_pkg::MODE_BACKUP;
            psc_pkg::DEPTH_OFF:     depth_mode = psc_pkg::MODE_OFF;
            default:                depth_mode = psc_pkg::MODE_ACTIVE;
        endcase
    endfunction

    // ****************************************
    // sleep mode sequencing
    // ****************************************
    assign after_handler = lnk.handler_return && lnk.sleep_after_handler
                        && (depth_r == psc_pkg::DEPTH_IDLE || depth_r == psc_pkg::DEPTH_STANDBY);

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            psc_pkg::MODE_ACTIVE: begin
                if (lnk.wait_for_interrupt_instr || after_handler) begin
                    mode_nxt = depth_mode(depth_r);
                end
            end
            psc_pkg::MODE_IDLE: begin
                if (irq_i) mode_nxt = psc_pkg::MODE_ACTIVE;
            end
            psc_pkg::MODE_STANDBY: begin
                if (async_irq_i || (sync_irq_i && sync_irq_keep_running_in_standby_i)) begin
                    mode_nxt = psc_pkg::MODE_ACTIVE;
                end
            end
            psc_pkg::MODE_BACKUP: begin
                if (backup_reset_i) mode_nxt = psc_pkg::MODE_ACTIVE;
            end
            psc_pkg::MODE_OFF: begin
                if (!ext_reset_n_i || power_reset_i) mode_nxt = psc_pkg::MODE_ACTIVE;
            end
            default: mode_nxt = psc_pkg::MODE_ACTIVE;
        endcase
    end

    assign enter_backup = (mode_r != psc_pkg::MODE_BACKUP) && (mode_nxt == psc_pkg::MODE_BACKUP);
    assign leave_backup = (mode_r == psc_pkg::MODE_BACKUP) && (mode_nxt != psc_pkg::MODE_BACKUP);

    // only sys_rst_i (power-on) reinitialises; pin and backup resets only wake
    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i) mode_r <= psc_pkg::MODE_ACTIVE;
        else               mode_r <= mode_nxt;
    end

    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i) begin
            lnk.wake          <= 1'b0;
            lnk.enter_handler <= 1'b0;
        end else begin
            lnk.wake <= (mode_r == psc_pkg::MODE_IDLE || mode_r == psc_pkg::MODE_STANDBY)
                     && mode_nxt == psc_pkg::MODE_ACTIVE;
            if (mode_r == psc_pkg::MODE_STANDBY && mode_nxt == psc_pkg::MODE_ACTIVE) begin
                lnk.enter_handler <= !lnk.cpu_interrupt_mask;
            end else if (mode_r == psc_pkg::MODE_IDLE && mode_nxt == psc_pkg::MODE_ACTIVE) begin
                lnk.enter_handler <= 1'b1;
            end
        end
    end

    // ****************************************
    // register port
    // ****************************************
    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i)          bus_off_r <= 1'b0;
        else if (bus_clk_disable_i) bus_off_r <= 1'b1;
    end

    assign wr = lnk.reg_req && lnk.reg_we && !bus_off_r;

    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i || enter_backup) begin
            depth_r <= psc_pkg::DEPTH_RST;
        end else if (wr && lnk.reg_addr == psc_pkg::SLEEP_CFG_IDX) begin
            depth_r <= lnk.reg_wdata[2:0];
        end
    end

    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i) begin
            io_retention_hold_r <= 1'b0;
        end else if (wr && lnk.reg_addr == psc_pkg::CTRL_A_IDX) begin
            io_retention_hold_r <= lnk.reg_wdata[psc_pkg::IO_RETENTION_HOLD_BIT]; // kept over backup
        end
    end

    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i) begin
            io_hold_r <= 1'b0;
        end else if (enter_backup) begin
            io_hold_r <= 1'b1;
        end else if (leave_backup && !io_retention_hold_r) begin
            io_hold_r <= 1'b0;
        end else if (mode_r != psc_pkg::MODE_BACKUP && wr
                     && lnk.reg_addr == psc_pkg::CTRL_A_IDX
                     && !lnk.reg_wdata[psc_pkg::IO_RETENTION_HOLD_BIT]) begin
            io_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i) begin
            lnk.reg_ack   <= 1'b0;
            lnk.reg_rdata <= 8'h00;
        end else begin
            lnk.reg_ack   <= lnk.reg_req;
            lnk.reg_rdata <= 8'h00;
            if (lnk.reg_req && !lnk.reg_we && !bus_off_r) begin
                case (lnk.reg_addr)
                    psc_pkg::CTRL_A_IDX:    lnk.reg_rdata[psc_pkg::IO_RETENTION_HOLD_BIT] <= io_retention_hold_r;
                    psc_pkg::SLEEP_CFG_IDX: lnk.reg_rdata[2:0] <= depth_r;
                    psc_pkg::PERF_CFG_IDX: begin
                        lnk.reg_rdata[psc_pkg::PERF_LEVEL_SELECT_BIT]  <= perf_level_select_r;
                        lnk.reg_rdata[psc_pkg::FREEZE_BIT] <= freeze_r;
                    end
                    default: begin
                        lnk.reg_rdata[psc_pkg::PERF_LEVEL_READY_FLAG_BIT]  <= perf_level_ready_flag_r;
                        lnk.reg_rdata[psc_pkg::SLPRDY_BIT] <= slprdy_r;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // performance level
    // ****************************************
    assign freeze_ok  = (level_r == psc_pkg::LOWEST_PERF) && (perf_level_select_r == psc_pkg::LOWEST_PERF);
    assign freeze_new = freeze_ok ? lnk.reg_wdata[psc_pkg::FREEZE_BIT] : freeze_r;
    assign sel_reject = freeze_new && lnk.reg_wdata[psc_pkg::PERF_LEVEL_SELECT_BIT] != psc_pkg::LOWEST_PERF;
    assign pl_done    = (mode_r == psc_pkg::MODE_ACTIVE) && (perf_level_select_r != level_r)
                     && (pl_cnt_r == psc_pkg::PL_CNT_W'(psc_pkg::PL_TRANS_CYC - 1));

    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i || enter_backup) begin
            perf_level_select_r            <= psc_pkg::LOWEST_PERF;
            freeze_r           <= 1'b0;
            access_violation_o <= 1'b0;
        end else begin
            access_violation_o <= 1'b0;
            if (wr && lnk.reg_addr == psc_pkg::PERF_CFG_IDX) begin
                freeze_r <= freeze_new;
                if (!sel_reject) perf_level_select_r <= lnk.reg_wdata[psc_pkg::PERF_LEVEL_SELECT_BIT];
                access_violation_o <= sel_reject
                    || (!freeze_ok && lnk.reg_wdata[psc_pkg::FREEZE_BIT] != freeze_r);
            end
        end
    end

    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i || enter_backup) begin
            level_r  <= psc_pkg::LOWEST_PERF;
            pl_cnt_r <= '0;
        end else if (perf_level_select_r == level_r) begin
            pl_cnt_r <= '0;
        end else if (pl_done) begin
            level_r  <= perf_level_select_r;
            pl_cnt_r <= '0;
        end else if (mode_r == psc_pkg::MODE_ACTIVE) begin
            pl_cnt_r <= pl_cnt_r + 1'b1;
        end
    end

    // ****************************************
    // flags: set wins over write-one clear
    // ****************************************
    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i || enter_backup) begin
            perf_level_ready_flag_r  <= 1'b0;
            slprdy_r <= 1'b0;
        end else begin
            if (pl_done) begin
                perf_level_ready_flag_r <= 1'b1;
            end else if (wr && lnk.reg_addr == psc_pkg::INT_FLAG_IDX
                         && lnk.reg_wdata[psc_pkg::PERF_LEVEL_READY_FLAG_BIT]) begin
                perf_level_ready_flag_r <= 1'b0;
            end
            if (vreg_stable_i) begin
                slprdy_r <= 1'b1;
            end else if (wr && lnk.reg_addr == psc_pkg::INT_FLAG_IDX
                         && lnk.reg_wdata[psc_pkg::SLPRDY_BIT]) begin
                slprdy_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // registered power outputs
    // ****************************************
    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i) begin
            mode_o         <= 3'h0;
            main_clk_en_o  <= 1'b1;
            bus_clk_en_o   <= 1'b1;
            generic_clock_en_o      <= 1'b1;
            regulator_lp_o <= 1'b0;
            io_hold_o      <= 1'b0;
            perf_level_o   <= psc_pkg::LOWEST_PERF;
            lnk.cpu_stop   <= 1'b0;
            lnk.perf_high  <= 1'b0;
            lnk.sleep_rdy  <= 1'b0;
        end else begin
            mode_o         <= mode_r;
            main_clk_en_o  <= mode_r == psc_pkg::MODE_ACTIVE || mode_r == psc_pkg::MODE_IDLE;
            bus_clk_en_o   <= mode_r == psc_pkg::MODE_ACTIVE || (bus_req_i
                && (mode_r == psc_pkg::MODE_IDLE || mode_r == psc_pkg::MODE_STANDBY));
            generic_clock_en_o      <= mode_r == psc_pkg::MODE_ACTIVE || mode_r == psc_pkg::MODE_IDLE
                || (mode_r == psc_pkg::MODE_STANDBY && clk_keep_i);
            regulator_lp_o <= mode_r == psc_pkg::MODE_STANDBY && !bg_task_power_i;
            io_hold_o      <= io_hold_r;
            perf_level_o   <= level_r;
            lnk.cpu_stop   <= mode_r != psc_pkg::MODE_ACTIVE;
            lnk.perf_high  <= level_r != psc_pkg::LOWEST_PERF;
            lnk.sleep_rdy  <= slprdy_r;
        end
    end
endmodule // psc_power_manager

// >>> psc_pkg.sv
// constants shared by the sleep and performance-level controller ends
package psc_pkg;
    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_MHZ      = 200;
    localparam int PL_TRANS_NS  = 20;
    localparam int PL_TRANS_CYC = (PL_TRANS_NS * CLK_MHZ + 999) / 1000;
    localparam int PL_CNT_W     = 4;

    // ****************************************
    // device register indices and fields
    // ****************************************
    localparam logic [1:0] CTRL_A_IDX     = 2'h0;
    localparam logic [1:0] SLEEP_CFG_IDX  = 2'h1;
    localparam logic [1:0] PERF_CFG_IDX   = 2'h2;
    localparam logic [1:0] INT_FLAG_IDX   = 2'h3;
    localparam int         IO_RETENTION_HOLD_BIT      = 2;
    localparam int         PERF_LEVEL_SELECT_BIT      = 0;
    localparam int         FREEZE_BIT     = 7;
    localparam int         PERF_LEVEL_READY_FLAG_BIT      = 0;
    localparam int         SLPRDY_BIT     = 1;
    localparam logic [2:0] DEPTH_RST      = 3'h0;
    localparam logic [2:0] DEPTH_IDLE     = 3'h2;
    localparam logic [2:0] DEPTH_STANDBY  = 3'h4;
    localparam logic [2:0] DEPTH_BACKUP   = 3'h5;
    localparam logic [2:0] DEPTH_OFF      = 3'h6;
    localparam logic       LOWEST_PERF    = 1'h0;

    // ****************************************
    // host wishbone register byte offsets
    // ****************************************
    localparam logic [3:0] H_CMD_OFS  = 4'h0;
    localparam logic [3:0] H_DATA_OFS = 4'h4;
    localparam logic [3:0] H_STAT_OFS = 4'h8;
    localparam logic [3:0] H_CTRL_OFS = 4'hc;
    localparam int         CMD_WR_BIT = 8;
    localparam int         CMD_RD_BIT = 9;
    localparam int         CMD_WFI_BIT = 10;
    localparam int         CMD_RET_BIT = 11;

    typedef enum logic [2:0] {
        MODE_ACTIVE, MODE_IDLE, MODE_STANDBY, MODE_BACKUP, MODE_OFF
    } psc_mode_t;
endpackage

// >>> psc_link_if.sv
// link between the cpu-side controller and the power manager
`timescale 1ns/1ps
interface psc_link_if (
    input wire logic clk_i,
    input wire logic sys_rst_i
);
    logic       reg_req;
    logic       reg_we;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_ack;
    logic [7:0] reg_rdata;
    logic       wait_for_interrupt_instr;
    logic       handler_return;
    logic       sleep_after_handler;
    logic       cpu_interrupt_mask;
    logic       cpu_stop;
    logic       wake;
    logic       enter_handler;
    logic       perf_high;
    logic       sleep_rdy;

    modport dev (
        input  clk_i, sys_rst_i, reg_req, reg_we, reg_addr, reg_wdata, wait_for_interrupt_instr,
               handler_return, sleep_after_handler, cpu_interrupt_mask,
        output reg_ack, reg_rdata, cpu_stop, wake, enter_handler, perf_high, sleep_rdy
    );
    modport cpu (
        input  clk_i, sys_rst_i, reg_ack, reg_rdata, cpu_stop, wake, enter_handler,
               perf_high, sleep_rdy,
        output reg_req, reg_we, reg_addr, reg_wdata, wait_for_interrupt_instr, handler_return,
               sleep_after_handler, cpu_interrupt_mask
    );
endinterface

// >>> psc_cpu_ctrl.sv
// cpu-side controller: wishbone orders turned into link accesses
`timescale 1ns/1ps
module psc_cpu_ctrl (
    // link to the power manager
    psc_link_if.cpu     lnk,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // bus clock permission
    output logic             bus_fast_ok_o
);
    typedef enum logic {H_IDLE, H_WAIT} psc_host_st_t;
    psc_host_st_t st_r;
    logic [7:0]   data_r;
    logic         wb_req;
    logic         cmd_wr;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cmd_wr = wb_req && wb_we_i && wb_sel_i[1] && wb_adr_i == psc_pkg::H_CMD_OFS
                 && st_r == H_IDLE;

    // ****************************************
    // wishbone answer
    // ****************************************
    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            case (wb_adr_i)
                psc_pkg::H_DATA_OFS: wb_dat_o[7:0] <= data_r;
                psc_pkg::H_STAT_OFS: wb_dat_o[4:0] <= {lnk.sleep_rdy, lnk.perf_high,
                    lnk.enter_handler, lnk.cpu_stop, st_r == H_WAIT};
                psc_pkg::H_CTRL_OFS: wb_dat_o[1:0] <= {lnk.cpu_interrupt_mask,
                    lnk.sleep_after_handler};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i) begin
            lnk.sleep_after_handler <= 1'b0;
            lnk.cpu_interrupt_mask  <= 1'b0;
        end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == psc_pkg::H_CTRL_OFS) begin
            lnk.sleep_after_handler <= wb_dat_i[0];
            lnk.cpu_interrupt_mask  <= wb_dat_i[1];
        end
    end

    // ****************************************
    // link access sequencing
    // ****************************************
    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i) begin
            st_r               <= H_IDLE;
            lnk.reg_req        <= 1'b0;
            lnk.reg_we         <= 1'b0;
            lnk.reg_addr       <= 2'h0;
            lnk.reg_wdata      <= 8'h00;
            lnk.wait_for_interrupt_instr            <= 1'b0;
            lnk.handler_return <= 1'b0;
            data_r             <= 8'h00;
        end else begin
            lnk.reg_req        <= 1'b0;
            lnk.wait_for_interrupt_instr            <= cmd_wr && wb_dat_i[psc_pkg::CMD_WFI_BIT] && !lnk.cpu_stop;
            lnk.handler_return <= cmd_wr && wb_dat_i[psc_pkg::CMD_RET_BIT];
            if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == psc_pkg::H_DATA_OFS
                && st_r == H_IDLE) begin
                data_r <= wb_dat_i[7:0];
            end
            case (st_r)
                H_IDLE: begin
                    if (cmd_wr && (wb_dat_i[psc_pkg::CMD_WR_BIT] || wb_dat_i[psc_pkg::CMD_RD_BIT])) begin
                        lnk.reg_req   <= 1'b1;
                        lnk.reg_we    <= wb_dat_i[psc_pkg::CMD_WR_BIT];
                        lnk.reg_addr  <= wb_dat_i[1:0];
                        lnk.reg_wdata <= data_r;
                        st_r          <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    if (lnk.reg_ack) begin
                        if (!lnk.reg_we) data_r <= lnk.reg_rdata;
                        st_r <= H_IDLE;
                    end
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end

    // ****************************************
    // bus clock permission
    // ****************************************
    always_ff @(posedge lnk.clk_i) begin
        if (lnk.sys_rst_i) begin
            bus_fast_ok_o <= 1'b0;
        end else if (cmd_wr && wb_dat_i[psc_pkg::CMD_WR_BIT] && wb_dat_i[1:0] == psc_pkg::PERF_CFG_IDX
                     && data_r[psc_pkg::PERF_LEVEL_SELECT_BIT] == psc_pkg::LOWEST_PERF) begin
            bus_fast_ok_o <= 1'b0;
        end else begin
            bus_fast_ok_o <= lnk.perf_high;
        end
    end
endmodule // psc_cpu_ctrl

// >>> psc_link_asserts.sv
// concurrent checks on the link between the two controller ends
`timescale 1ns/1ps
module psc_link_asserts (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    // link signals
    input wire logic       reg_req,
    input wire logic       reg_we,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_ack,
    input wire logic [7:0] reg_rdata,
    input wire logic       wait_for_interrupt_instr,
    input wire logic       handler_return,
    input wire logic       sleep_after_handler,
    input wire logic       cpu_stop,
    input wire logic       wake,
    input wire logic       perf_high,
    input wire logic       sleep_rdy
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_ack_next; reg_req |=> reg_ack; endproperty
    a_ack_next: assert property (p_ack_next) else $error("link ack missing");
    property p_ack_cause; reg_ack |-> $past(reg_req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("link ack unasked");
    property p_rdata_idle; !reg_ack |-> reg_rdata == 8'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
    property p_rst_vals;
        @(posedge clk_i) disable iff (1'h0)
        sys_rst_i |=> !cpu_stop && !perf_high && !sleep_rdy;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset state");
    property p_sleep_cause;
        $rose(cpu_stop) |-> $past(wait_for_interrupt_instr) || $past(wait_for_interrupt_instr, 2)
            || $past(handler_return && sleep_after_handler)
            || $past(handler_return && sleep_after_handler, 2);
    endproperty
    a_sleep_cause: assert property (p_sleep_cause) else $error("sleep w/o wfi");
    property p_wfi_gate; wait_for_interrupt_instr |-> !cpu_stop; endproperty
    a_wfi_gate: assert property (p_wfi_gate) else $error("wfi while stopped");
    property p_wake_pulse; wake |=> !wake && !cpu_stop; endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("bad wake pulse");
    property p_perf_delay;
        reg_req && reg_we && reg_addr == psc_pkg::PERF_CFG_IDX && reg_wdata[0]
            && !perf_high |=> !perf_high [*4];
    endproperty
    a_perf_delay: assert property (p_perf_delay) else $error("level too early");
    property p_perf_active; $rose(perf_high) |-> !$past(cpu_stop); endproperty
    a_perf_active: assert property (p_perf_active) else $error("level in sleep");
    c_wake: cover property (wake);
    c_stop: cover property ($rose(cpu_stop));
    c_perf: cover property ($rose(perf_high));
endmodule // psc_link_asserts

// >>> tb_top.sv
// self-checking bench for the sleep and performance-level controller
`timescale 1ns/1ps
module tb_top;
    logic        clk_i = 1'h0;
    logic        sys_rst_i = 1'h1;
    logic        cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, q, dat_o;
    logic        ack, f;
    logic [11:0] u = 12'h020;
    logic [2:0]  m;
    logic [6:0]  o;
    int          n_errors = 0, n_tests = 0, n_viol = 0;
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (o[6] === 1'h1) n_viol++;
    psc_link_if lnk (.clk_i(clk_i), .sys_rst_i(sys_rst_i));
    psc_power_manager psc_power_manager_i (.lnk(lnk), .irq_i(u[0]), .async_irq_i(u[1]),
        .sync_irq_i(u[2]), .sync_irq_keep_running_in_standby_i(u[3]), .backup_reset_i(u[4]),
        .ext_reset_n_i(u[5]), .power_reset_i(u[6]), .bus_req_i(u[7]), .clk_keep_i(u[8]),
        .bg_task_power_i(u[9]), .vreg_stable_i(u[10]), .bus_clk_disable_i(u[11]),
        .mode_o(m), .main_clk_en_o(o[0]), .bus_clk_en_o(o[1]), .generic_clock_en_o(o[2]),
        .regulator_lp_o(o[3]), .io_hold_o(o[4]), .perf_level_o(o[5]),
        .access_violation_o(o[6]));
    psc_cpu_ctrl psc_cpu_ctrl_i (.lnk(lnk), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .bus_fast_ok_o(f));
    psc_link_asserts psc_link_asserts_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .reg_req(lnk.reg_req), .reg_we(lnk.reg_we), .reg_addr(lnk.reg_addr),
        .reg_wdata(lnk.reg_wdata), .reg_ack(lnk.reg_ack), .reg_rdata(lnk.reg_rdata),
        .wait_for_interrupt_instr(lnk.wait_for_interrupt_instr), .handler_return(lnk.handler_return),
        .sleep_after_handler(lnk.sleep_after_handler), .cpu_stop(lnk.cpu_stop),
        .wake(lnk.wake), .perf_high(lnk.perf_high), .sleep_rdy(lnk.sleep_rdy));
    task stop_test;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task chb(input logic g, input logic e);
        chk({7'h0, g}, {7'h0, e});
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
        do @(posedge clk_i); while (ack !== 1'h1);
        q = dat_o;
        {cyc, stb} <= 2'h0;
    endtask
    task cmd(input logic [31:0] c);
        wb(1'h1, psc_pkg::H_CMD_OFS, c);
        do wb(1'h0, psc_pkg::H_STAT_OFS, 32'h0); while (q[0] !== 1'h0);
    endtask
    task dac(input logic [1:0] k, input logic [1:0] i, input logic [7:0] d);
        wb(1'h1, psc_pkg::H_DATA_OFS, {24'h0, d});
        cmd({22'h0, k, 6'h0, i});
        wb(1'h0, psc_pkg::H_DATA_OFS, 32'h0);
    endtask
    task slp(input logic [2:0] d);
        dac(2'h1, psc_pkg::SLEEP_CFG_IDX, {5'h0, d});
        dac(2'h2, psc_pkg::SLEEP_CFG_IDX, 8'h0);
        chk(q[7:0], {5'h0, d});
        cmd(32'h400);
        repeat (3) @(posedge clk_i);
    endtask
    task pu(input int k);
        @(posedge clk_i) u[k] <= ~u[k];
        @(posedge clk_i) u[k] <= ~u[k];
        repeat (3) @(posedge clk_i);
    endtask
    task pl(input logic [7:0] v);
        dac(2'h1, psc_pkg::PERF_CFG_IDX, v);
        repeat (8) @(posedge clk_i);
    endtask
    initial begin #100000; n_errors++; stop_test(); end
    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        @(posedge clk_i);
        chk({m, o[4:0]}, 8'h07);
        chb(o[5], 1'h0);
        u[10] <= 1'h1;
        repeat (3) @(posedge clk_i);
        wb(1'h0, psc_pkg::H_STAT_OFS, 32'h0);
        chb(q[4], 1'h1);
        slp(psc_pkg::DEPTH_IDLE);
        chk({m, o[4:0]}, 8'h25);
        u[7] <= 1'h1;
        repeat (3) @(posedge clk_i);
        chb(o[1], 1'h1);
        u[7] <= 1'h0;
        pu(0);
        wb(1'h0, psc_pkg::H_STAT_OFS, 32'h0);
        chk({m, 3'h0, q[2:1]}, 8'h02);
        wb(1'h1, psc_pkg::H_CTRL_OFS, 32'h2);
        slp(psc_pkg::DEPTH_STANDBY);
        chk({m, o[4:0]}, 8'h48);
        pu(9);
        u[9] <= 1'h1;
        repeat (3) @(posedge clk_i);
        chb(o[3], 1'h0);
        u[9] <= 1'h0;
        pu(2);
        chk({5'h0, m}, 8'h02);
        pu(1);
        wb(1'h0, psc_pkg::H_STAT_OFS, 32'h0);
        chk({m, 3'h0, q[2:1]}, 8'h00);
        wb(1'h1, psc_pkg::H_CTRL_OFS, 32'h3);
        cmd(32'h800);
        repeat (3) @(posedge clk_i);
        chk({5'h0, m}, 8'h02);
        pu(1);
        wb(1'h1, psc_pkg::H_CTRL_OFS, 32'h0);
        slp(3'h3);
        chk({5'h0, m}, 8'h00);
        slp(psc_pkg::DEPTH_OFF);
        chk({5'h0, m}, 8'h04);
        pu(5);
        chk({5'h0, m}, 8'h00);
        for (int r = 1; r >= 0; r--) begin
            dac(2'h1, psc_pkg::CTRL_A_IDX, {5'h0, r[0], 2'h0});
            chb(o[4], 1'h0);
            slp(psc_pkg::DEPTH_BACKUP);
            chk({m, 1'h0, o[4], 3'h0}, 8'h68);
            pu(4);
            chk({m, 1'h0, o[4], 3'h0}, {3'h0, 1'h0, r[0], 3'h0});
            dac(2'h2, psc_pkg::CTRL_A_IDX, 8'h0);
            chb(q[psc_pkg::IO_RETENTION_HOLD_BIT], r[0]);
        end
        pl(8'h01);
        chb(o[5], 1'h1);
        chb(f, 1'h1);
        dac(2'h2, psc_pkg::INT_FLAG_IDX, 8'h0);
        chb(q[psc_pkg::PERF_LEVEL_READY_FLAG_BIT], 1'h1);
        pl(8'h81);
        chk(n_viol[7:0], 8'h01);
        pl(8'h00);
        chb(f, 1'h0);
        pl(8'h80);
        pl(8'h81);
        chk({n_viol[6:0], o[5]}, 8'h04);
        u[11] <= 1'h1;
        dac(2'h1, psc_pkg::SLEEP_CFG_IDX, 8'h02);
        dac(2'h2, psc_pkg::SLEEP_CFG_IDX, 8'h0);
        chk(q[7:0], 8'h00);
        stop_test();
    end
endmodule // tb_top
